//--- ssebk_bank.sv
`timescale 1ns/1ps
module ssebk_bank (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire ssebk_pkg::ssebk_bus_type bus_i,
   input wire ssebk_pkg::ssebk_core_type core_i,
   input wire ssebk_pkg::ssebk_nvm_type nvm_i,
   output logic [15:0] rdata_o,
   output logic rvalid_o,
   output logic selftest_go_o,
   output logic [3:0] action_code_o,
   output logic turns_reset_o,
   output logic hard_reset_o,
   output logic action_busy_o
);
   import ssebk_pkg::*;

   typedef struct packed {
      ssebk_act_type act;
      logic busy;
      logic [3:0] special;
      logic action_finished;
      logic boot_finished;
      logic [11:0] fault;
      logic [11:0] seen;
      logic [15:0] rdata;
      logic rvalid;
      logic selftest_go;
      logic [3:0] action_code;
      logic turns_go;
      logic hard_go;
   } ssebk_state_type;

   ssebk_state_type st;
   ssebk_state_type next_st;

   function automatic logic key_fits(input logic [3:0] act, input logic [7:0] key);
      logic ok;
      ok = 1'b0;
      case (act)
         ACT_FIELD_ST, ACT_LOGIC_ST, ACT_BOTH_ST: ok = (key == KEY_SELFTEST);
         ACT_TURNS: ok = (key == KEY_TURNS);
         ACT_HARDRST: ok = (key == KEY_HARDRST);
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : key_fits

   function automatic logic odd_fill(input logic [14:0] bits);
      return ~(^bits);
   endfunction : odd_fill

   // action field and trigger key always arrive in one control write
   function automatic logic [3:0] act_of(input logic [15:0] w);
      return w[ACT_MSB:ACT_LSB];
   endfunction : act_of

   function automatic logic [7:0] key_of(input logic [15:0] w);
      return w[KEY_MSB:KEY_LSB];
   endfunction : key_of

   logic any_fault_flag;
   logic supply_low_now;
   logic wr_ctrl;
   logic trigger;
   logic clear_done_bits;
   logic clear_fault;
   logic [11:0] fault_set;
   logic [15:0] position_reading;
   logic [15:0] device_condition;
   logic [15:0] fault_word;

   // summary covers latched faults plus live caution state
   assign any_fault_flag = (|(st.fault & ~nvm_i.mask_bits)) | core_i.caution_unmasked;
   assign supply_low_now = (core_i.events.supply_pin_low & ~nvm_i.mask_bits[FB_SUPPLY])
      | (core_i.events.regulator_low & ~nvm_i.mask_bits[FB_REGULATOR]);
   assign position_reading = {1'b0, any_fault_flag, supply_low_now,
      odd_fill({any_fault_flag, supply_low_now, core_i.angle}), core_i.angle};
   assign device_condition = {TAG_COND, 2'b00, nvm_i.die_number,
      core_i.turning_direction, core_i.too_fast_for_sleep,
      st.action_finished, st.boot_finished,
      core_i.logic_selftest_active, core_i.field_selftest_active, core_i.boot_active,
      core_i.tracking_locked & core_i.startup_done};
   assign fault_word = {TAG_FAULT, st.fault};

   assign wr_ctrl = bus_i.wr && (bus_i.addr == ADDR_CTRL);
   assign trigger = wr_ctrl && (st.act == ACT_IDLE)
      && key_fits(act_of(bus_i.wdata), key_of(bus_i.wdata));
   assign clear_done_bits = wr_ctrl && bus_i.wdata[CTRL_CLEAR_DONE];
   assign clear_fault = wr_ctrl && bus_i.wdata[CTRL_CLEAR_FAULT];
   assign fault_set = {core_i.caution_unmasked & ~nvm_i.mask_bits[FB_CAUTION],
      core_i.events, 1'b0};

   always_comb begin
      next_st = st;
      next_st.rvalid = 1'b0;
      next_st.selftest_go = 1'b0;
      next_st.turns_go = 1'b0;
      next_st.hard_go = 1'b0;
      // reads only pick up the word; the seen mask is hidden bookkeeping
      if (bus_i.rd && !bus_i.wr) begin
         next_st.rvalid = 1'b1;
         case (bus_i.addr)
            ADDR_CTRL: next_st.rdata = {st.special, 12'h000};
            ADDR_POS: next_st.rdata = position_reading;
            ADDR_COND: next_st.rdata = device_condition;
            ADDR_FAULT: begin
               next_st.rdata = fault_word;
               next_st.seen = st.seen | st.fault;
            end
            default: next_st.rdata = WORD_ZERO;
         endcase
      end
      if (wr_ctrl) begin
         next_st.special = act_of(bus_i.wdata);
      end
      // fault bits: clear only what was read, and a new event wins
      if (clear_fault) begin
         next_st.seen = '0;
         next_st.fault = (st.fault & ~st.seen) | fault_set;
      end else begin
         next_st.fault = st.fault | fault_set;
      end
      if (clear_done_bits) begin
         next_st.action_finished = 1'b0;
         next_st.boot_finished = 1'b0;
      end
      if (core_i.boot_done) begin
         next_st.boot_finished = 1'b1;
      end
      case (st.act)
         ACT_IDLE: begin
            if (trigger) begin
               next_st.act = ACT_RUN;
               next_st.busy = 1'b1;
               next_st.action_finished = 1'b0;
               next_st.action_code = act_of(bus_i.wdata);
               next_st.selftest_go = (key_of(bus_i.wdata) == KEY_SELFTEST);
               next_st.turns_go = (key_of(bus_i.wdata) == KEY_TURNS);
               next_st.hard_go = (key_of(bus_i.wdata) == KEY_HARDRST);
            end
         end
         ACT_RUN: begin
            // completion beats a same-cycle clear-done
            if (core_i.action_done) begin
               next_st.act = ACT_IDLE;
               next_st.busy = 1'b0;
               next_st.action_finished = 1'b1;
               next_st.special = ACT_NONE;
            end
         end
         default: begin
            next_st.act = ACT_IDLE;
            next_st.busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         st <= '{act: ACT_IDLE, special: ACT_NONE, fault: FAULT_RESET, default: '0};
      end else begin
         st <= next_st;
      end
   end

   assign rdata_o = st.rdata;
   assign rvalid_o = st.rvalid;
   assign selftest_go_o = st.selftest_go;
   assign action_code_o = st.action_code;
   assign turns_reset_o = st.turns_go;
   assign hard_reset_o = st.hard_go;
   // busy is its own flop so the pin never shows a decode glitch
   assign action_busy_o = st.busy;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   a_key_reads_zero: assert property (
      bus_i.rd && !bus_i.wr && bus_i.addr == ADDR_CTRL |=> rdata_o[7:0] == 8'h00 && rvalid_o)
      else $error("trigger key field read back nonzero");
   a_selftest_launch: assert property (
      wr_ctrl && st.act == ACT_IDLE && act_of(bus_i.wdata) == ACT_FIELD_ST
      && key_of(bus_i.wdata) == KEY_SELFTEST
      |=> selftest_go_o && action_busy_o ##1 !selftest_go_o)
      else $error("self-test key did not launch one pulse");
   a_wrong_key: assert property (
      wr_ctrl && act_of(bus_i.wdata) == ACT_TURNS && key_of(bus_i.wdata) != KEY_TURNS
      |=> !turns_reset_o)
      else $error("turns reset launched with wrong key");
   a_pos_layout: assert property (
      bus_i.rd && !bus_i.wr && bus_i.addr == ADDR_POS
      |=> !rdata_o[15] && rdata_o[11:0] == $past(core_i.angle)
      && rdata_o[13] == $past(supply_low_now) && rdata_o[14] == $past(any_fault_flag))
      else $error("position word layout wrong");
   a_pos_parity: assert property (
      bus_i.rd && !bus_i.wr && bus_i.addr == ADDR_POS |=> ^rdata_o)
      else $error("position word parity not odd");
   a_cond_tag: assert property (
      bus_i.rd && !bus_i.wr && bus_i.addr == ADDR_COND
      |=> rdata_o[15:12] == TAG_COND && rdata_o[9:8] == $past(nvm_i.die_number))
      else $error("condition word tag or die number wrong");
   a_fault_tag: assert property (
      bus_i.rd && !bus_i.wr && bus_i.addr == ADDR_FAULT |=> rdata_o[15:12] == TAG_FAULT)
      else $error("fault word tag wrong");
   a_fault_sticky: assert property (
      !clear_fault |=> (st.fault & $past(st.fault)) == $past(st.fault))
      else $error("fault bit dropped without clear");
   a_unread_kept: assert property (
      clear_fault && st.fault[FB_SUPPLY] && !st.seen[FB_SUPPLY] |=> st.fault[FB_SUPPLY])
      else $error("unread fault bit was cleared");
   a_supply_resets: assert property (
      core_i.events.supply_pin_low |=> st.fault[FB_SUPPLY])
      else $error("supply low did not set fault bit");
   a_done_cycle: assert property (
      trigger |=> !st.action_finished)
      else $error("action finished flag not cleared at launch");
   a_done_set: assert property (
      action_busy_o && core_i.action_done |=> st.action_finished)
      else $error("action finished flag not set at completion");
   a_clear_done: assert property (
      clear_done_bits && !core_i.boot_done && !(core_i.action_done && action_busy_o)
      |=> !st.boot_finished && !st.action_finished)
      else $error("clear-done left a finished bit set");


   // position word bits, checked one cycle after the read edge
   a_summary_clear: assert property (
      bus_i.rd && !bus_i.wr && bus_i.addr == ADDR_POS && !core_i.caution_unmasked
      && (st.fault & ~nvm_i.mask_bits) == '0 |=> !rdata_o[14])
      else $error("fault summary set with nothing unmasked");
   a_summary_set: assert property (
      bus_i.rd && !bus_i.wr && bus_i.addr == ADDR_POS
      && (st.fault & ~nvm_i.mask_bits) != '0 |=> rdata_o[14])
      else $error("fault summary missed an unmasked fault");
   a_supply_live: assert property (
      bus_i.rd && !bus_i.wr && bus_i.addr == ADDR_POS && core_i.events.supply_pin_low
      && !nvm_i.mask_bits[FB_SUPPLY] |=> rdata_o[13])
      else $error("live supply low not shown");
   a_supply_quiet: assert property (
      bus_i.rd && !bus_i.wr && bus_i.addr == ADDR_POS && !core_i.events.supply_pin_low
      && !core_i.events.regulator_low |=> !rdata_o[13])
      else $error("live supply low shown without a condition");

   // condition word bits and control word readback
   a_cond_live: assert property (
      bus_i.rd && !bus_i.wr && bus_i.addr == ADDR_COND
      |=> rdata_o[7:6] == $past({core_i.turning_direction, core_i.too_fast_for_sleep})
      && rdata_o[3:1] == $past({core_i.logic_selftest_active, core_i.field_selftest_active,
      core_i.boot_active}))
      else $error("condition word live bits wrong");
   a_cond_finished: assert property (
      bus_i.rd && !bus_i.wr && bus_i.addr == ADDR_COND
      |=> rdata_o[5:4] == $past({st.action_finished, st.boot_finished}))
      else $error("condition word finished bits wrong");
   a_angle_valid: assert property (
      bus_i.rd && !bus_i.wr && bus_i.addr == ADDR_COND
      && !(core_i.tracking_locked && core_i.startup_done) |=> !rdata_o[0])
      else $error("angle reported valid without lock and start-up");
   a_boot_sets: assert property (
      core_i.boot_done |=> st.boot_finished)
      else $error("boot finished flag not set");
   a_ctrl_low_zero: assert property (
      bus_i.rd && !bus_i.wr && bus_i.addr == ADDR_CTRL |=> rdata_o[11:0] == 12'h000)
      else $error("control clear bits read back nonzero");

   // fault latch
   a_caution_latch: assert property (
      core_i.caution_unmasked && !nvm_i.mask_bits[FB_CAUTION] |=> st.fault[FB_CAUTION])
      else $error("unmasked caution did not latch");
   a_caution_masked: assert property (
      nvm_i.mask_bits[FB_CAUTION] && !st.fault[FB_CAUTION] |=> !st.fault[FB_CAUTION])
      else $error("masked caution latched");
   a_events_latch: assert property (
      core_i.events != '0
      |=> (st.fault[10:1] & $past(core_i.events)) == $past(core_i.events))
      else $error("fault event did not latch");
   a_reset_flag: assert property (
      $past(rst_i) |-> st.fault == FAULT_RESET && !action_busy_o && !st.action_finished)
      else $error("reset state wrong after release");
   a_read_quiet: assert property (
      bus_i.rd && !bus_i.wr && fault_set == '0 && !core_i.boot_done && !core_i.action_done
      |=> $stable(st.fault) && $stable(st.action_finished) && $stable(st.boot_finished))
      else $error("a read changed a flag");

   // action launch and completion
   a_busy_refuses: assert property (
      action_busy_o && !core_i.action_done
      |=> !selftest_go_o && !turns_reset_o && !hard_reset_o)
      else $error("action launched while another was running");
   a_key_refused: assert property (
      wr_ctrl && !trigger && !action_busy_o
      |=> !selftest_go_o && !turns_reset_o && !hard_reset_o && !action_busy_o)
      else $error("action launched without a fitting key");
   a_one_launch: assert property (
      trigger |=> $onehot({selftest_go_o, turns_reset_o, hard_reset_o}))
      else $error("launch pulses not exactly one");
   a_turns_launch: assert property (
      trigger && key_of(bus_i.wdata) == KEY_TURNS
      |=> turns_reset_o && action_code_o == ACT_TURNS)
      else $error("turns reset key did not launch");
   a_hard_launch: assert property (
      trigger && key_of(bus_i.wdata) == KEY_HARDRST
      |=> hard_reset_o && action_code_o == ACT_HARDRST)
      else $error("hard reset key did not launch");
   a_special_ends: assert property (
      action_busy_o && core_i.action_done |=> st.special == ACT_NONE && !action_busy_o)
      else $error("action field not returned to zero at completion");

   c_selftest: cover property (trigger && key_of(bus_i.wdata) == KEY_SELFTEST);
   c_fault_clear: cover property (st.fault[FB_SUPPLY] && clear_fault && st.seen[FB_SUPPLY]);
   c_action_end: cover property (action_busy_o && core_i.action_done);
   c_hard_reset: cover property (trigger && key_of(bus_i.wdata) == KEY_HARDRST);
   c_boot_clear: cover property (clear_done_bits && st.boot_finished);
endmodule : ssebk_bank

//--- ssebk_pkg.sv
// Overview of operation
// - choose action in action field and write trigger key in the same control write; key field reads zero
// - key 0xB9 starts self-tests, 0x46 turns counter reset, 0x5A hard reset
// - position word: bit15 zero, 14 fault summary, 13 undervoltage, 12 parity, 11:0 angle
// - fault summary is one when any unmasked fault or caution bit is set
// - live undervoltage is unmasked supply-pin low or unmasked regulator low
// - parity makes the whole 16-bit position word hold an odd count of ones
// - angle is unsigned 12 bits, degrees equal value times 360 over 4096
// - bits 15:12 carry tag 1000 in condition word, 1010 in fault word
// - condition bits 9:8 show die number from nonvolatile memory, no sensing effect
// - condition bit 7 shows turning direction, 0 increasing, 1 decreasing
// - condition bit 6 shows rotation too fast for sleep entry
// - bit 5 clears on action trigger, sets on completion, clears on clear-done write
// - bit 4 sets when boot finishes, clears on clear-done write
// - bits 3, 2, 1 show logic self-test, field self-test and boot running
// - bit 0 is one only when tracking locked and start-up completed
// - fault bits stay set until read then cleared; reset flag set after power-on
// - fault bit 11 sets on unmasked caution bit, mask can suppress it
// - fault bit 10 sets when either self-test fails
// - bit 9 sets on averaging corruption, bit 8 on quadrature integrity loss
// - bit 7 sets on tracking lock loss, bit 6 on zero crossing timeout
// - bit 5 sets on multi-bit memory error at load, bit 4 on oscillator trip
// - bit 3 sets on supply-pin low and sets again after clear while low
// - writing one to clear-done clears action and boot finished bits
// - writing one to clear-fault clears only fault bits read before; reads zero
package ssebk_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h1E;
   localparam logic [7:0] ADDR_POS = 8'h20;
   localparam logic [7:0] ADDR_COND = 8'h22;
   localparam logic [7:0] ADDR_FAULT = 8'h24;
   localparam logic [7:0] KEY_SELFTEST = 8'hB9;
   localparam logic [7:0] KEY_TURNS = 8'h46;
   localparam logic [7:0] KEY_HARDRST = 8'h5A;
   localparam logic [3:0] ACT_NONE = 4'h0;
   localparam logic [3:0] ACT_TURNS = 4'h4;
   localparam logic [3:0] ACT_HARDRST = 4'h7;
   localparam logic [3:0] ACT_FIELD_ST = 4'h9;
   localparam logic [3:0] ACT_LOGIC_ST = 4'hA;
   localparam logic [3:0] ACT_BOTH_ST = 4'hB;
   localparam logic [3:0] TAG_COND = 4'h8;
   localparam logic [3:0] TAG_FAULT = 4'hA;
   localparam int CTRL_CLEAR_DONE = 10;
   localparam int CTRL_CLEAR_FAULT = 8;
   localparam int ACT_MSB = 15;
   localparam int ACT_LSB = 12;
   localparam int KEY_MSB = 7;
   localparam int KEY_LSB = 0;
   localparam int FB_CAUTION = 11;
   localparam int FB_SUPPLY = 3;
   localparam int FB_REGULATOR = 2;
   localparam logic [11:0] FAULT_RESET = 12'h001;
   localparam logic [15:0] WORD_ZERO = 16'h0000;

   typedef enum logic [1:0] {
      ACT_IDLE = 2'b00,
      ACT_RUN = 2'b01
   } ssebk_act_type;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [15:0] wdata;
   } ssebk_bus_type;

   // fault events for latch bits 10 down to 1
   typedef struct packed {
      logic check_failed;
      logic averaging_fault;
      logic quadrature_integrity_fault;
      logic tracking_lock_lost;
      logic zero_cross_timeout;
      logic nvm_multibit_fault;
      logic oscillator_watchdog_trip;
      logic supply_pin_low;
      logic regulator_low;
      logic field_low;
   } ssebk_event_type;

   typedef struct packed {
      logic [11:0] angle;
      logic turning_direction;
      logic too_fast_for_sleep;
      logic tracking_locked;
      logic startup_done;
      logic boot_active;
      logic logic_selftest_active;
      logic field_selftest_active;
      logic caution_unmasked;
      logic boot_done;
      logic action_done;
      ssebk_event_type events;
   } ssebk_core_type;

   typedef struct packed {
      logic [1:0] die_number;
      logic [11:0] mask_bits;
   } ssebk_nvm_type;
endpackage : ssebk_pkg

//--- test_sensor_status_error_bank.sv
`timescale 1ns/1ps
module test_sensor_status_error_bank;
   import ssebk_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   ssebk_bus_type bus_i = '0;
   ssebk_core_type core_i = '0;
   ssebk_nvm_type nvm_i = '0;
   logic [15:0] rdata_o;
   logic rvalid_o;
   logic selftest_go_o;
   logic [3:0] action_code_o;
   logic turns_reset_o;
   logic hard_reset_o;
   logic action_busy_o;
   logic [15:0] got;
   logic [11:0] lat;
   ssebk_core_type cv;
   logic [3:0] acts [5] = '{ACT_FIELD_ST, ACT_LOGIC_ST, ACT_BOTH_ST, ACT_TURNS, ACT_HARDRST};
   logic [7:0] keys [5] = '{KEY_SELFTEST, KEY_SELFTEST, KEY_SELFTEST, KEY_TURNS, KEY_HARDRST};
   int n_fail = 0;
   int checks = 0;

   always #25 mclk_i = ~mclk_i;

   ssebk_bank dut (.mclk_i(mclk_i), .rst_i(rst_i), .bus_i(bus_i), .core_i(core_i),
      .nvm_i(nvm_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .selftest_go_o(selftest_go_o),
      .action_code_o(action_code_o), .turns_reset_o(turns_reset_o),
      .hard_reset_o(hard_reset_o), .action_busy_o(action_busy_o));

   task end_sim;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim

   task check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // one idle edge first, so back-to-back calls never retoggle a strobe in one step
   task rd(input logic [7:0] a);
      @(negedge mclk_i);
      bus_i.rd = 1'b1;
      bus_i.addr = a;
      @(negedge mclk_i);
      bus_i.rd = 1'b0;
      check({15'h0000, rvalid_o}, 16'h0001);
      got = rdata_o;
   endtask : rd

   task wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge mclk_i);
      bus_i.wr = 1'b1;
      bus_i.addr = a;
      bus_i.wdata = d;
      @(negedge mclk_i);
      bus_i.wr = 1'b0;
   endtask : wr

   function automatic logic [15:0] pos_exp(ssebk_core_type c, ssebk_nvm_type n, logic [11:0] l);
      logic summ;
      logic low;
      summ = (|(l & ~n.mask_bits)) | c.caution_unmasked;
      low = (c.events.supply_pin_low & ~n.mask_bits[FB_SUPPLY])
         | (c.events.regulator_low & ~n.mask_bits[FB_REGULATOR]);
      return {1'b0, summ, low, ~^{summ, low, c.angle}, c.angle};
   endfunction : pos_exp

   function automatic logic [15:0] cond_exp(ssebk_core_type c, ssebk_nvm_type n);
      return {TAG_COND, 2'b00, n.die_number, c.turning_direction, c.too_fast_for_sleep,
         2'b00, c.logic_selftest_active, c.field_selftest_active, c.boot_active,
         c.tracking_locked & c.startup_done};
   endfunction : cond_exp

   initial begin
      #100000;
      n_fail++;
      end_sim();
   end

   initial begin
      void'($urandom(32'h6ecc));
      lat = FAULT_RESET;
      repeat (3) @(negedge mclk_i);
      rst_i = 1'b0;
      // only the two supply events vary, so the bench can track the latch exactly
      repeat (24) begin
         cv = ssebk_core_type'($urandom);
         cv.boot_done = 1'b0;
         cv.action_done = 1'b0;
         cv.events = '0;
         cv.events.supply_pin_low = 1'($urandom);
         cv.events.regulator_low = 1'($urandom);
         core_i = cv;
         nvm_i = ssebk_nvm_type'(14'($urandom) | 14'(1 << FB_CAUTION));
         // the read waits an idle edge, so the latch already holds this round's events
         lat[FB_SUPPLY] = lat[FB_SUPPLY] | cv.events.supply_pin_low;
         lat[FB_REGULATOR] = lat[FB_REGULATOR] | cv.events.regulator_low;
         rd(ADDR_POS);
         check(got, pos_exp(core_i, nvm_i, lat));
         rd(ADDR_COND);
         check(got, cond_exp(core_i, nvm_i));
      end
      core_i = '0;
      nvm_i = '0;
      rd(ADDR_FAULT);
      check(got, {TAG_FAULT, lat});
      cv = '0;
      cv.events = 10'h244;
      cv.caution_unmasked = 1'b1;
      core_i = cv;
      @(negedge mclk_i);
      cv = '0;
      cv.events.supply_pin_low = 1'b1;
      core_i = cv;
      wr(ADDR_CTRL, 16'h0100);
      rd(ADDR_FAULT);
      check(got, 16'hAC88);
      rd(ADDR_FAULT);
      check(got, 16'hAC88);
      core_i.events.supply_pin_low = 1'b0;
      wr(ADDR_CTRL, 16'h0100);
      rd(ADDR_FAULT);
      check(got, 16'hA000);
      for (int i = 0; i < 5; i++) begin
         wr(ADDR_CTRL, {acts[i], 4'h0, keys[i]});
         check({selftest_go_o, turns_reset_o, hard_reset_o, action_busy_o, 8'h00, action_code_o},
            {keys[i] == KEY_SELFTEST, keys[i] == KEY_TURNS, keys[i] == KEY_HARDRST, 1'b1,
            8'h00, acts[i]});
         rd(ADDR_CTRL);
         check(got, {acts[i], 12'h000});
         rd(ADDR_COND);
         check({15'h0000, got[5]}, 16'h0000);
         core_i.action_done = 1'b1;
         @(negedge mclk_i);
         core_i.action_done = 1'b0;
         rd(ADDR_COND);
         check({15'h0000, got[5]}, 16'h0001);
         rd(ADDR_CTRL);
         check(got, WORD_ZERO);
      end
      // key that does not fit the chosen action must launch nothing
      wr(ADDR_CTRL, 16'h9046);
      check({13'h0000, selftest_go_o, turns_reset_o, action_busy_o}, 16'h0000);
      rd(ADDR_CTRL);
      check(got, 16'h9000);
      core_i.boot_done = 1'b1;
      @(negedge mclk_i);
      core_i.boot_done = 1'b0;
      rd(ADDR_COND);
      check({14'h0000, got[5:4]}, 16'h0003);
      wr(ADDR_CTRL, 16'h0400);
      rd(ADDR_COND);
      check({14'h0000, got[5:4]}, 16'h0000);
      rd(8'h30);
      check(got, WORD_ZERO);
      end_sim();
   end
endmodule : test_sensor_status_error_bank
